// file: inc/cse_pkg.sv
// constants and types for the compare-skip, decimal adjust and decrement execution block
package cse_pkg;

    // ****************************************
    // apb register offsets (byte addresses)
    // ****************************************
    localparam logic [7:0] CSE_ADDR_CTRL = 8'h00;
    localparam logic [7:0] CSE_ADDR_ACC = 8'h04;
    localparam logic [7:0] CSE_ADDR_FLAGS = 8'h08;
    localparam logic [7:0] CSE_ADDR_BANK = 8'h0C;
    localparam logic [7:0] CSE_ADDR_STATE = 8'h10;

    // ****************************************
    // field positions and reset values
    // ****************************************
    localparam int CSE_CTRL_EN_BIT = 0;
    localparam logic CSE_CTRL_EN_RST = 1'b1;
    localparam logic [7:0] CSE_ACC_RST = 8'h00;
    localparam logic [3:0] CSE_BANK_RST = 4'h0;

    // ****************************************
    // instruction encodings
    // ****************************************
    localparam logic [6:0] CSE_OPC_LT = 7'h30;  // 0110 000a
    localparam logic [6:0] CSE_OPC_GT = 7'h32;  // 0110 010a
    localparam logic [5:0] CSE_OPC_DEC = 6'h01; // 0000 01da
    localparam logic [15:0] CSE_OPC_DAW = 16'h0007;

    // ****************************************
    // arithmetic and addressing constants
    // ****************************************
    localparam logic [3:0] CSE_BCD_MAX = 4'h9;
    localparam logic [8:0] CSE_DAW_LO = 9'h006;
    localparam logic [8:0] CSE_DAW_HI = 9'h060;
    localparam logic [8:0] CSE_DEC_ADD = 9'h0FF;
    localparam logic [4:0] CSE_DEC_NIB = 5'h0F;
    localparam logic [7:0] CSE_ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] CSE_ACCESS_LO_BANK = 4'h0;
    localparam logic [3:0] CSE_ACCESS_HI_BANK = 4'hF;

    // ****************************************
    // quarter phases and skip lengths
    // ****************************************
    localparam logic [1:0] CSE_Q1 = 2'h0;
    localparam logic [1:0] CSE_Q2 = 2'h1;
    localparam logic [1:0] CSE_Q3 = 2'h2;
    localparam logic [1:0] CSE_Q4 = 2'h3;
    localparam logic [1:0] CSE_SKIP_ONE = 2'h1;
    localparam logic [1:0] CSE_SKIP_TWO = 2'h2;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [2:0] {CSE_OP_NONE, CSE_OP_LT, CSE_OP_GT, CSE_OP_DAW, CSE_OP_DEC} cse_op_t;

    typedef struct packed {
        logic n;
        logic ov;
        logic z;
        logic dc;
        logic c;
    } cse_flags_t;

    localparam cse_flags_t CSE_FLAGS_RST = 5'h00;

    typedef struct packed {
        logic [11:0] addr;
        logic rd;
        logic wr;
        logic [7:0] wdata;
    } cse_mem_req_t;

endpackage

// file: hw/cse_exec.sv
// execution logic for compare-skip, decimal adjust and decrement-file instructions
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/10ps

// How it works
// RULE_01: upper byte 0110 000a decodes compare_skip_if_less; low byte is file address.
// RULE_02: compares subtract file from accumulator unsigned, store nothing, flags untouched.
// RULE_03: file below accumulator discards the fetched instruction, a no_operation runs instead.
// RULE_04: access bit 0 uses the access bank, 1 uses the bank_select_register.
// RULE_05: compare takes 1 cycle, 2 on skip, 3 when skipping a two-word instruction.
// RULE_06: each skipped word is one full cycle with all four quarters idle.
// RULE_07: low nibble above 9 or digit_carry_flag set gets 6 added.
// RULE_08: high nibble above 9 or carry set gets 6 added.
// RULE_09: decimal_adjust_acc has no operand, fixes the accumulator to packed BCD.
// RULE_10: decrement_file 01da subtracts one, d picks destination, sets C DC N OV Z.
// RULE_11: upper byte 0110 010a decodes compare_skip_if_greater, skips when file is greater.
// RULE_12: decimal adjust sets carry when the high adjustment overflows the byte.
// RULE_13: decode Q1, read Q2, process Q3, write Q4; compares write nothing.
module cse_exec
    import cse_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic [15:0] i_instr,
    input wire logic i_instr_valid,
    input wire logic i_next_two_word,
    output logic [1:0] o_phase,
    output logic o_claimed,
    output logic o_discard,
    output logic o_nop_active,
    output cse_mem_req_t o_mem,
    input wire logic [7:0] i_mem_rdata,
    output logic [7:0] o_acc,
    output cse_flags_t o_flags
);

    // ****************************************
    // internal state
    // ****************************************
    logic ctrl_en;
    logic [3:0] bank_sel;
    cse_op_t op;
    logic [15:0] ir;
    logic [7:0] opnd;
    logic [7:0] res;
    cse_flags_t res_flags;
    logic wr_acc;
    logic [1:0] nop_left;
    logic last_skip;
    logic apb_wr;
    logic apb_hit;

    cse_op_t next_op;
    logic [11:0] next_addr;
    logic [7:0] next_res;
    cse_flags_t next_flags;
    logic next_wr_acc;
    logic next_wr_mem;
    logic next_skip;

    // ****************************************
    // quarter phase divider
    // ****************************************
    // one clock per quarter, four clocks make one instruction cycle
    // reset always restarts at Q1, so the first edge after it already samples a word
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_phase <= CSE_Q1;
        end else begin
            o_phase <= o_phase + 2'h1;
        end
    end

    // ****************************************
    // decode and address
    // ****************************************
    // instruction classes of this group; anything else is left to the rest of the core
    // limitation: the equal and not-equal compares and the decrement-and-skip forms are
    // not decoded here, so such words leave o_claimed low and are executed elsewhere
    always_comb begin
        next_op = CSE_OP_NONE;
        if (i_instr[15:9] == CSE_OPC_LT) begin
            next_op = CSE_OP_LT; // [RULE_01]
        end else if (i_instr[15:9] == CSE_OPC_GT) begin
            next_op = CSE_OP_GT; // [RULE_11]
        end else if (i_instr[15:10] == CSE_OPC_DEC) begin
            next_op = CSE_OP_DEC; // [RULE_10]
        end else if (i_instr == CSE_OPC_DAW) begin
            next_op = CSE_OP_DAW; // [RULE_09]
        end
    end

    // access bit low maps the file address into the shared access bank
    always_comb begin
        if (i_instr[8]) begin
            next_addr = {bank_sel, i_instr[7:0]}; // [RULE_04]
        end else if (i_instr[7:0] < CSE_ACCESS_SPLIT) begin
            next_addr = {CSE_ACCESS_LO_BANK, i_instr[7:0]}; // [RULE_04]
        end else begin
            next_addr = {CSE_ACCESS_HI_BANK, i_instr[7:0]}; // [RULE_04]
        end
    end

    // latch at the end of Q1; a skipped slot or a disabled block claims nothing
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            op <= CSE_OP_NONE;
            ir <= 16'h0000;
            o_claimed <= 1'b0;
        end else if (o_phase == CSE_Q1) begin
            if (ctrl_en && i_instr_valid && !o_nop_active) begin
                op <= next_op; // [RULE_13]
                ir <= i_instr;
                o_claimed <= (next_op != CSE_OP_NONE);
            end else begin
                op <= CSE_OP_NONE; // [RULE_06]
                o_claimed <= 1'b0;
            end
        end
    end

    // ****************************************
    // data memory port
    // ****************************************
    // read strobe spans Q2, write strobe spans Q4; memory answers within the Q2 clock
    // the address is set once at Q1 and held to Q4, so read and write of a decrement
    // always hit the same file register even if the bank select changes meanwhile
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_mem <= '0;
        end else begin
            unique case (o_phase)
                CSE_Q1: begin
                    o_mem.addr <= next_addr;
                    o_mem.rd <= ctrl_en && i_instr_valid && !o_nop_active
                                && (next_op inside {CSE_OP_LT, CSE_OP_GT, CSE_OP_DEC}); // [RULE_13]
                end
                CSE_Q2: begin
                    o_mem.rd <= 1'b0;
                end
                CSE_Q3: begin
                    o_mem.wr <= next_wr_mem; // [RULE_13]
                    o_mem.wdata <= next_res;
                end
                CSE_Q4: begin
                    o_mem.wr <= 1'b0;
                end
            endcase
        end
    end

    // operand capture at the end of Q2; decimal adjust reads the accumulator itself
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            opnd <= 8'h00;
        end else if (o_phase == CSE_Q2) begin
            opnd <= (op == CSE_OP_DAW) ? o_acc : i_mem_rdata; // [RULE_13]
        end
    end

    // ****************************************
    // process data
    // ****************************************
    always_comb begin
        logic [8:0] sum;
        logic [8:0] t1;
        logic [8:0] t2;
        logic [4:0] nib;
        sum = {1'b0, opnd} + CSE_DEC_ADD;
        nib = {1'b0, opnd[3:0]} + CSE_DEC_NIB;
        t1 = {1'b0, opnd};
        t2 = t1;
        next_res = opnd;
        next_flags = o_flags;
        next_wr_acc = 1'b0;
        next_wr_mem = 1'b0;
        next_skip = 1'b0;
        unique case (op)
            CSE_OP_LT: begin
                // unsigned compare only; neither result nor flags are kept
                next_skip = (opnd < o_acc); // [RULE_02] [RULE_03]
            end
            CSE_OP_GT: begin
                next_skip = (opnd > o_acc); // [RULE_02] [RULE_11]
            end
            CSE_OP_DEC: begin
                // subtract as add of all ones: carry means no borrow
                next_res = sum[7:0]; // [RULE_10]
                next_flags.c = sum[8];
                next_flags.dc = nib[4];
                next_flags.n = sum[7];
                next_flags.ov = opnd[7] & ~sum[7];
                next_flags.z = (sum[7:0] == 8'h00);
                next_wr_acc = ~ir[9];
                next_wr_mem = ir[9];
            end
            CSE_OP_DAW: begin
                // low fix first, its carry runs into the high nibble test
                if ((opnd[3:0] > CSE_BCD_MAX) || o_flags.dc) begin
                    t1 = {1'b0, opnd} + CSE_DAW_LO; // [RULE_07]
                end
                if ((t1[7:4] > CSE_BCD_MAX) || o_flags.c || t1[8]) begin
                    t2 = t1 + CSE_DAW_HI; // [RULE_08]
                end else begin
                    t2 = t1;
                end
                next_res = t2[7:0]; // [RULE_09]
                next_flags.c = o_flags.c | t1[8] | t2[8]; // [RULE_12]
                next_wr_acc = 1'b1;
            end
            CSE_OP_NONE: begin
                next_res = opnd;
            end
            default: begin
                next_res = opnd;
            end
        endcase
    end

    // result held from Q3 so the Q4 write sees stable data
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            res <= 8'h00;
            res_flags <= CSE_FLAGS_RST;
            wr_acc <= 1'b0;
        end else if (o_phase == CSE_Q3) begin
            res <= next_res;
            res_flags <= next_flags;
            wr_acc <= next_wr_acc;
        end
    end

    // ****************************************
    // skip sequencing
    // ****************************************
    // decision at Q3 end; discard pulse covers Q4, idle cycles follow from next Q1
    // the length of the following word is only known once it is fetched, so the core
    // must present i_next_two_word by the Q3 edge; a late flag gives a one-cycle skip
    // the idle count is loaded in Q3 but only counted down in Q4 of an idle cycle,
    // which keeps the Q1 claim logic blind to words that arrive while it runs
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            nop_left <= 2'h0;
            o_discard <= 1'b0;
            o_nop_active <= 1'b0;
            last_skip <= 1'b0;
        end else if (o_phase == CSE_Q3) begin
            if (op == CSE_OP_LT || op == CSE_OP_GT) begin
                last_skip <= next_skip;
                o_discard <= next_skip; // [RULE_03]
                if (next_skip) begin
                    nop_left <= i_next_two_word ? CSE_SKIP_TWO : CSE_SKIP_ONE; // [RULE_05]
                end
            end
        end else if (o_phase == CSE_Q4) begin
            o_discard <= 1'b0;
            if (o_nop_active) begin
                nop_left <= nop_left - 2'h1; // [RULE_06]
                o_nop_active <= (nop_left > CSE_SKIP_ONE);
            end else begin
                o_nop_active <= (nop_left != 2'h0); // [RULE_05]
            end
        end
    end

    // ****************************************
    // apb slave
    // ****************************************
    // one wait state: pready rises on the second access cycle, hazard-free decode
    assign apb_wr = i_psel && i_penable && o_pready && i_pwrite;
    assign apb_hit = (i_paddr == CSE_ADDR_CTRL) || (i_paddr == CSE_ADDR_ACC)
                     || (i_paddr == CSE_ADDR_FLAGS) || (i_paddr == CSE_ADDR_BANK)
                     || (i_paddr == CSE_ADDR_STATE);

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= 32'h0000_0000;
        end else if (i_psel && i_penable && !o_pready) begin
            o_pready <= 1'b1;
            o_pslverr <= !apb_hit;
            o_prdata <= 32'h0000_0000;
            if (!i_pwrite) begin
                unique case (i_paddr)
                    CSE_ADDR_CTRL: o_prdata <= {31'h0, ctrl_en};
                    CSE_ADDR_ACC: o_prdata <= {24'h0, o_acc};
                    CSE_ADDR_FLAGS: o_prdata <= {27'h0, o_flags};
                    CSE_ADDR_BANK: o_prdata <= {28'h0, bank_sel};
                    // status word: phase [1:0], op [4:2], idle count [6:5], idle flag [7],
                    // last decision [8], claim [9]; a debug snapshot, the phase moves on at once
                    CSE_ADDR_STATE: o_prdata <= {22'h0, o_claimed, last_skip, o_nop_active,
                                                 nop_left, op, o_phase};
                    default: o_prdata <= 32'h0000_0000;
                endcase
            end
        end else begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
        end
    end

    // ****************************************
    // architectural registers
    // ****************************************
    // core write in Q4 wins over a software write landing on the same edge
    // trade-off: software loses that write silently rather than stalling the bus,
    // so firmware should only touch ACC or FLAGS while the block is disabled
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ctrl_en <= CSE_CTRL_EN_RST;
            bank_sel <= CSE_BANK_RST;
            o_acc <= CSE_ACC_RST;
            o_flags <= CSE_FLAGS_RST;
        end else begin
            if (apb_wr && i_paddr == CSE_ADDR_CTRL) begin
                ctrl_en <= i_pwdata[CSE_CTRL_EN_BIT];
            end
            if (apb_wr && i_paddr == CSE_ADDR_BANK) begin
                bank_sel <= i_pwdata[3:0];
            end
            if (o_phase == CSE_Q4 && wr_acc) begin
                o_acc <= res; // [RULE_13]
            end else if (apb_wr && i_paddr == CSE_ADDR_ACC) begin
                o_acc <= i_pwdata[7:0];
            end
            // compares never reach here, so their flags stay as they were
            if (o_phase == CSE_Q4 && (op == CSE_OP_DEC || op == CSE_OP_DAW)) begin
                o_flags <= res_flags; // [RULE_02] [RULE_10]
            end else if (apb_wr && i_paddr == CSE_ADDR_FLAGS) begin
                o_flags <= i_pwdata[4:0];
            end
        end
    end

endmodule

// file: tb/cse_exec_sva.sv
// concurrent checks on the execution block ports
`timescale 1ns/10ps
module cse_exec_chk
    import cse_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic o_pready,
    input wire logic [1:0] o_phase,
    input wire logic o_discard,
    input wire logic o_nop_active,
    input wire cse_mem_req_t o_mem,
    input wire logic [7:0] i_mem_rdata,
    input wire logic [7:0] o_acc,
    input wire cse_flags_t o_flags
);
    // ****************************************
    // idle run length and assertions
    // ****************************************
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    logic [3:0] nop_run;
    // counts the current idle run so its length can be judged when it ends
    always_ff @(posedge i_clk) begin
        if (i_rst || !o_nop_active) begin
            nop_run <= 4'h0;
        end else begin
            nop_run <= nop_run + 4'h1;
        end
    end
    a_phase_step: assert property (!$past(i_rst) |-> o_phase == $past(o_phase) + 2'h1)
        else $error("quarter phase did not advance by one");
    a_read_q2: assert property (o_mem.rd |-> o_phase == CSE_Q2)
        else $error("file read outside the second quarter");
    a_write_q4: assert property (o_mem.wr |-> o_phase == CSE_Q4)
        else $error("file write outside the fourth quarter");
    a_dec_value: assert property (o_mem.wr |-> o_mem.wdata == $past(i_mem_rdata, 2) - 8'h01)
        else $error("written value is not the file value minus one");
    a_skip_idle: assert property (o_discard |-> (o_phase == CSE_Q4 && !o_mem.wr) ##1 o_nop_active [*4])
        else $error("discard not followed by a full idle cycle");
    a_idle_len: assert property (!$past(i_rst) && $fell(o_nop_active) |-> nop_run == 4'h4 || nop_run == 4'h8)
        else $error("idle run is neither one nor two instruction cycles");
    a_idle_max: assert property (o_nop_active |-> nop_run < 4'h8)
        else $error("idle run longer than two instruction cycles");
    a_idle_quiet: assert property (o_nop_active |-> !o_mem.rd && !o_mem.wr && !o_discard)
        else $error("activity during an idle cycle");
    a_cmp_keeps: assert property (o_discard && !(i_psel && i_penable && i_pwrite && o_pready)
        |=> $stable(o_flags) && $stable(o_acc))
        else $error("compare changed accumulator or flags");
    a_acc_at_q4: assert property ($changed(o_acc) && !$past(i_psel && i_penable && i_pwrite && o_pready)
        |-> o_phase == CSE_Q1)
        else $error("accumulator changed away from the fourth quarter edge");
    a_ready_wait: assert property (i_psel && i_penable && !o_pready |=> o_pready)
        else $error("bus answer did not come after one wait");
    a_ready_pulse: assert property (o_pready |=> !o_pready)
        else $error("bus ready held longer than one cycle");
endmodule

bind cse_exec cse_exec_chk cse_exec_chk_inst (.i_clk, .i_rst, .i_psel, .i_penable, .i_pwrite, .o_pready,
    .o_phase, .o_discard, .o_nop_active, .o_mem, .i_mem_rdata, .o_acc, .o_flags);

// file: tb/cse_mem_model.sv
// banked data memory model answering file reads and writes
`timescale 1ns/10ps
module cse_mem_model
    import cse_pkg::*;
(
    input wire logic i_clk,
    input wire cse_mem_req_t i_mem,
    output logic [7:0] o_rdata
);
    // ****************************************
    // storage
    // ****************************************
    logic [7:0] mem [0:4095];
    logic [7:0] last = 8'h00;
    // data only while read stands; otherwise the inverse, so a late sample shows
    always_comb begin
        o_rdata = i_mem.rd ? mem[i_mem.addr] : ~last;
    end
    // a write lands at the edge closing the write cycle
    always @(posedge i_clk) begin
        if (i_mem.rd) begin
            last <= mem[i_mem.addr];
        end
        if (i_mem.wr) begin
            mem[i_mem.addr] <= i_mem.wdata;
        end
    end
endmodule

// file: tb/tb_cse_exec.sv
// self-checking bench for compare-skip, decimal adjust and decrement
`timescale 1ns/10ps
module tb_cse_exec
    import cse_pkg::*;
;
    // ****************************************
    // signals, tables and instances
    // ****************************************
    logic i_clk = 1'b0, i_rst = 1'b1, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
    logic [7:0] i_paddr = 8'h00, i_mem_rdata, o_acc;
    logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
    logic o_pready, o_pslverr, o_claimed, o_discard, o_nop_active, sl;
    logic [15:0] i_instr = 16'h0000;
    logic i_instr_valid = 1'b0, i_next_two_word = 1'b0;
    logic [1:0] o_phase;
    cse_mem_req_t o_mem;
    cse_flags_t o_flags;
    int err_count = 0, total_checks = 0, nops = 0, discards = 0, claims = 0, nop0, dis0, clm0;
    logic [7:0] ra [5] = '{CSE_ADDR_CTRL, CSE_ADDR_ACC, CSE_ADDR_FLAGS, CSE_ADDR_BANK, 8'h14};
    logic [15:0] ci [6] = '{16'h6020, 16'h6020, 16'h6120, 16'h6470, 16'h6520, 16'h6520};
    logic [11:0] ca [6] = '{12'h020, 12'h020, 12'h320, 12'hF70, 12'h320, 12'h320};
    logic [7:0] cv [6] = '{8'h30, 8'h50, 8'h4F, 8'h51, 8'h50, 8'hFF};
    logic [5:0] ct = 6'h24, cs = 6'h2D;
    logic [7:0] dv [3] = '{8'h80, 8'h01, 8'h00}, da [3] = '{8'h7F, 8'h00, 8'hFF}, df [3] = '{8'h09, 8'h07, 8'h10};
    logic [7:0] wa [5] = '{8'hA5, 8'hCE, 8'h12, 8'h72, 8'h45}, wf [5] = '{8'h00, 8'h00, 8'h02, 8'h01, 8'h00};
    logic [7:0] xa [5] = '{8'h05, 8'h34, 8'h18, 8'hD2, 8'h45}, xf [5] = '{8'h01, 8'h01, 8'h02, 8'h01, 8'h00};
    cse_exec cse_exec_inst (.i_clk, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
        .o_pready, .o_pslverr, .i_instr, .i_instr_valid, .i_next_two_word, .o_phase, .o_claimed, .o_discard,
        .o_nop_active, .o_mem, .i_mem_rdata, .o_acc, .o_flags);
    cse_mem_model cse_mem_model_inst (.i_clk, .i_mem(o_mem), .o_rdata(i_mem_rdata));
    // 40 MHz clock
    always #12.5 i_clk = ~i_clk;
    // idle clocks, discard clocks and claimed clocks counted from time zero; the compare and decrement tests take differences
    always @(posedge i_clk) begin
        nops += (o_nop_active === 1'b1);
        discards += (o_discard === 1'b1);
        claims += (o_claimed === 1'b1);
    end
    // ****************************************
    // tasks
    // ****************************************
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk_bus(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_core(input logic [7:0] got, input logic [7:0] exp);
        chk_bus({24'h0, got}, {24'h0, exp});
    endtask
    task automatic wait_out();
        err_count++;
        $display("CHECK FAILED at %0t: wait ran out", $time);
        test_done();
    endtask
    // one apb transfer; held until ready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n = 0;
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= wd;
        @(posedge i_clk);
        i_penable <= 1'b1;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_pready !== 1'b1 && n < 20);
        if (n >= 20) wait_out();
        rd = o_prdata;
        sl = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask
    // presents a word for the next first-quarter edge
    task automatic exec(input logic [15:0] ins, input logic two);
        int n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_phase !== CSE_Q4 && n < 20);
        if (n >= 20) wait_out();
        i_instr <= ins;
        i_instr_valid <= 1'b1;
        i_next_two_word <= two;
        @(posedge i_clk);
        i_instr_valid <= 1'b0;
    endtask
    // three harmless words so that the last instruction and any idle run are over
    task automatic flush();
        repeat (3) exec(16'h0000, 1'b0);
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (20) @(posedge i_clk);
        i_rst <= 1'b0;
        foreach (ra[k]) begin
            apb(1'b0, ra[k], 32'h0);
            chk_bus(rd, {31'h0, k == 0});
            chk_core({7'h0, sl}, {7'h0, k == 4});
        end
        apb(1'b1, CSE_ADDR_ACC, 32'h50);
        apb(1'b1, CSE_ADDR_BANK, 32'h3);
        apb(1'b0, CSE_ADDR_BANK, 32'h0);
        chk_bus(rd, 32'h3);
        $display("test registers done");
        // a decrement follows each compare; it must vanish when the compare skips
        foreach (ci[k]) begin
            cse_mem_model_inst.mem[ca[k]] = cv[k];
            cse_mem_model_inst.mem[12'h021] = 8'h10;
            apb(1'b1, CSE_ADDR_FLAGS, 32'h1E);
            nop0 = nops;
            dis0 = discards;
            clm0 = claims;
            exec(ci[k], ct[k]);
            exec(16'h0621, 1'b0);
            flush();
            chk_core(8'(nops - nop0), cs[k] ? (ct[k] ? 8'h08 : 8'h04) : 8'h00);
            chk_core(8'(discards - dis0), {7'h0, cs[k]});
            chk_core(8'(claims - clm0), cs[k] ? 8'h04 : 8'h08);
            chk_core(cse_mem_model_inst.mem[12'h021], cs[k] ? 8'h10 : 8'h0F);
            chk_core({3'h0, o_flags}, cs[k] ? 8'h1E : 8'h01);
            chk_core(o_acc, 8'h50);
        end
        // status after the last compare skipped: only the decision bit stands, phase masked
        apb(1'b0, CSE_ADDR_STATE, 32'h0);
        chk_bus(rd & 32'hFFFF_FFFC, 32'h0000_0100);
        $display("test compare done");
        foreach (dv[k]) begin
            cse_mem_model_inst.mem[12'h022] = dv[k];
            exec(16'h0422, 1'b0);
            flush();
            chk_core(o_acc, da[k]);
            chk_core({3'h0, o_flags}, df[k]);
            chk_core(cse_mem_model_inst.mem[12'h022], dv[k]);
        end
        // a disabled block claims nothing, so the decrement must leave the accumulator
        apb(1'b1, CSE_ADDR_CTRL, 32'h0);
        cse_mem_model_inst.mem[12'h022] = 8'h55;
        clm0 = claims;
        exec(16'h0422, 1'b0);
        flush();
        chk_core(8'(claims - clm0), 8'h00);
        chk_core(o_acc, 8'hFF);
        apb(1'b1, CSE_ADDR_CTRL, 32'h1);
        $display("test decrement done");
        foreach (wa[k]) begin
            apb(1'b1, CSE_ADDR_ACC, {24'h0, wa[k]});
            apb(1'b1, CSE_ADDR_FLAGS, {24'h0, wf[k]});
            exec(CSE_OPC_DAW, 1'b0);
            flush();
            chk_core(o_acc, xa[k]);
            chk_core({3'h0, o_flags}, xf[k]);
        end
        $display("test adjust done");
        test_done();
    end
endmodule
